// *** include/ccp_pkg.sv ***
// Register map, field positions and timing counts for the clock and power monitor block
package ccp_pkg;

    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;

    localparam logic [11:0] ADDR_CLK_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_DIVIDER   = 12'h004;
    localparam logic [11:0] ADDR_AUX       = 12'h008;
    localparam logic [11:0] ADDR_POWER     = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_EN    = 12'h010;
    localparam logic [11:0] ADDR_STATUS    = 12'h014;

    localparam int          CLKOUT_EN_BIT  = 4;
    localparam int          BO_IRQ_SEL_BIT = 5;
    localparam int          BO_DIS_BIT     = 6;
    localparam int          BOF_BIT        = 5;
    localparam int          POF_BIT        = 4;
    localparam int          GIE_BIT        = 7;
    localparam int          BO_IEN_BIT     = 5;
    localparam int          ST_HOLD_BIT    = 0;
    localparam int          ST_BELOW_BIT   = 1;
    localparam int          ST_CLKOUT_BIT  = 2;
    localparam int          ST_OSC_LSB     = 4;

    localparam logic [7:0]  DIVIDER_RESET  = 8'h00;

    localparam logic [1:0]  CLKOUT_LAST    = 2'h2;
    localparam logic [2:0]  MACHINE_LAST   = 3'h5;
    localparam logic [10:0] WAKE_XTAL      = 11'h400;
    localparam logic [10:0] WAKE_RC_EXT    = 11'h100;

    typedef enum logic [2:0] {
        OSC_XTAL_LOW,
        OSC_XTAL_MED,
        OSC_XTAL_HIGH,
        OSC_RC,
        OSC_EXT
    } ccp_osc_type;

    typedef enum logic {
        WAKE_RUN,
        WAKE_COUNT
    } ccp_wake_type;

endpackage

// *** logic/ccp_top.sv ***
// CPU clock divider, clock output and power monitor flags behind an APB slave
//
// Summary of operation
// - Clock output only with RC or external clock
// - Clock output runs at one sixth CPU rate
// - Clock output keeps toggling during Idle
// - External clock frees second pin as port
// - Six CPU clocks per machine cycle; half rate
// - Half rate slows peripherals too
// - Divider zero passes oscillator or half rate
// - Divider N from 1 up divides by 2*(N+1)
// - Divider change accepted anytime without stall
// - Brownout resets, or interrupts when selected
// - Brownout reset held while supply stays low
// - One interrupt per falling threshold crossing
// - Interrupt needs global and brownout enable
// - Brownout flag sticky until software clears
// - Level select: 1 is 2.5 V, 0 is 3.8 V
// - Disable bit stops all brownout effects
// - Power-on flag sticky until software clears
// - Clock output needs enable and non-crystal source
// - Wake-up waits 1024 or 256 CPU clocks
`timescale 1ns/100ps

module ccp_top (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ccp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [ccp_pkg::DATA_W-1:0] pwdata,
    output logic      [ccp_pkg::DATA_W-1:0] prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [2:0]               osc_select_cfg,
    input  wire logic                     half_rate_config,
    input  wire logic                     brownout_level_select,
    input  wire logic                     supply_below_low,
    input  wire logic                     supply_below_high,
    input  wire logic                     power_on_detect,
    input  wire logic                     wake_request,
    input  wire logic                     port_pin_out,
    input  wire logic                     port_pin_oe,
    output logic                          clock_out_pin,
    output logic                          clock_out_oe,
    output logic                          cpu_clk_tick,
    output logic                          machine_cycle_tick,
    output logic                          cpu_hold,
    output logic                          brownout_reset,
    output logic                          brownout_irq_request
);
    import ccp_pkg::*;

    // Synchronised straps and analog comparator levels
    logic [7:0]   sync_meta;
    logic [7:0]   sync_q;
    ccp_osc_type  osc_mode;
    logic         half_rate;
    logic         level_sel;
    logic         below_low;
    logic         below_high;
    logic         por_level;
    logic         por_prev;

    // Software visible state
    logic         clock_out_enable;
    logic [7:0]   cpu_clock_divider;
    logic         brownout_irq_select;
    logic         brownout_disable;
    logic         brownout_flag;
    logic         power_on_flag;
    logic         global_irq_enable;
    logic         brownout_irq_enable;

    // Clock generation
    logic         half_phase;
    logic         base_tick;
    logic [7:0]   div_active;
    logic [8:0]   div_count;
    logic [8:0]   div_limit;
    logic         next_cpu_tick;
    logic [2:0]   machine_count;
    logic [1:0]   clkout_count;
    logic         clkout_active;
    logic         port_mode;
    logic         is_xtal;

    // Brownout
    logic         below;
    logic         below_prev;
    logic         bo_edge;
    logic         bof_clear;
    logic         pof_clear;

    // Wake-up
    ccp_wake_type wake_state;
    ccp_wake_type next_wake_state;
    logic [10:0]  wake_count;
    logic [10:0]  wake_target;

    // APB
    logic         access;
    logic         wr_fire;
    logic [31:0]  read_word;

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == ADDR_CLK_CTRL) || (a == ADDR_DIVIDER) || (a == ADDR_AUX) ||
                      (a == ADDR_POWER) || (a == ADDR_IRQ_EN) || (a == ADDR_STATUS);
    endfunction

    function automatic logic osc_is_xtal(input ccp_osc_type m);
        osc_is_xtal = !((m == OSC_RC) || (m == OSC_EXT));
    endfunction

    // Every strap and comparator level passes two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= 8'h00;
            sync_q    <= 8'h00;
        end else begin
            sync_meta <= {osc_select_cfg, half_rate_config, brownout_level_select,
                          supply_below_low, supply_below_high, power_on_detect};
            sync_q    <= sync_meta;
        end
    end

    assign osc_mode   = ccp_osc_type'(sync_q[7:5]);
    assign half_rate  = sync_q[4];
    assign level_sel  = sync_q[3];
    assign below_low  = sync_q[2];
    assign below_high = sync_q[1];
    assign por_level  = sync_q[0];
    assign is_xtal    = osc_is_xtal(osc_mode);
    // Undefined strap codes fall back to crystal, the safe choice for the pin
    assign port_mode  = !is_xtal;

    // APB slave, one wait state
    assign access  = psel & penable;
    assign wr_fire = access & pready & pwrite & addr_mapped(paddr);

    always_comb begin
        read_word = 32'h0000_0000;
        case (paddr)
            ADDR_CLK_CTRL: read_word[CLKOUT_EN_BIT] = clock_out_enable;
            ADDR_DIVIDER:  read_word[7:0] = cpu_clock_divider;
            ADDR_AUX: begin
                read_word[BO_IRQ_SEL_BIT] = brownout_irq_select;
                read_word[BO_DIS_BIT]     = brownout_disable;
            end
            ADDR_POWER: begin
                read_word[BOF_BIT] = brownout_flag;
                read_word[POF_BIT] = power_on_flag;
            end
            ADDR_IRQ_EN: begin
                read_word[GIE_BIT]    = global_irq_enable;
                read_word[BO_IEN_BIT] = brownout_irq_enable;
            end
            ADDR_STATUS: begin
                read_word[ST_HOLD_BIT]                = cpu_hold;
                read_word[ST_BELOW_BIT]               = below;
                read_word[ST_CLKOUT_BIT]              = clkout_active;
                read_word[ST_OSC_LSB+2:ST_OSC_LSB]    = osc_mode;
            end
            default: read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access & !pready;
            pslverr <= access & !pready & !addr_mapped(paddr);
            prdata  <= (access & !pready & !pwrite) ? read_word : 32'h0000_0000;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_enable    <= 1'b0;
            cpu_clock_divider   <= DIVIDER_RESET;
            brownout_irq_select <= 1'b0;
            brownout_disable    <= 1'b0;
            global_irq_enable   <= 1'b0;
            brownout_irq_enable <= 1'b0;
        end else if (wr_fire) begin
            case (paddr)
                ADDR_CLK_CTRL: clock_out_enable <= pwdata[CLKOUT_EN_BIT];
                ADDR_DIVIDER:  cpu_clock_divider <= pwdata[7:0];
                ADDR_AUX: begin
                    brownout_irq_select <= pwdata[BO_IRQ_SEL_BIT];
                    brownout_disable    <= pwdata[BO_DIS_BIT];
                end
                ADDR_IRQ_EN: begin
                    global_irq_enable   <= pwdata[GIE_BIT];
                    brownout_irq_enable <= pwdata[BO_IEN_BIT];
                end
                default: clock_out_enable <= clock_out_enable;
            endcase
        end
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    assign bof_clear = wr_fire && (paddr == ADDR_POWER) && pwdata[BOF_BIT];
    assign pof_clear = wr_fire && (paddr == ADDR_POWER) && pwdata[POF_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_flag <= 1'b0;
            power_on_flag <= 1'b0;
            por_prev      <= 1'b0;
        end else begin
            por_prev <= por_level;
            if (bo_edge) begin
                brownout_flag <= 1'b1;
            end else if (bof_clear) begin
                brownout_flag <= 1'b0;
            end
            if (por_level && !por_prev) begin
                power_on_flag <= 1'b1;
            end else if (pof_clear) begin
                power_on_flag <= 1'b0;
            end
        end
    end

    // Brownout detection
    assign below   = level_sel ? below_low : below_high;
    assign bo_edge = !brownout_disable && below && !below_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_prev           <= 1'b0;
            brownout_reset       <= 1'b0;
            brownout_irq_request <= 1'b0;
        end else begin
            below_prev           <= below;
            brownout_reset       <= !brownout_disable && !brownout_irq_select && below;
            // Edge only, so a long sag raises one request
            brownout_irq_request <= bo_edge && brownout_irq_select &&
                                    global_irq_enable && brownout_irq_enable;
        end
    end

    // CPU clock strobe; half rate also slows every peripheral using the strobe
    assign base_tick = !half_rate || half_phase;
    assign div_limit = {div_active, 1'b1};
    assign next_cpu_tick = base_tick && (div_active == cpu_clock_divider) &&
                           ((div_active == 8'h00) || (div_count == div_limit));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_phase <= 1'b0;
            div_active <= DIVIDER_RESET;
            div_count  <= 9'h000;
        end else begin
            half_phase <= half_rate && !half_phase;
            if (div_active != cpu_clock_divider) begin
                // Restart the period so no strobe comes early
                div_active <= cpu_clock_divider;
                div_count  <= 9'h000;
            end else if (base_tick && (div_active != 8'h00)) begin
                div_count <= (div_count == div_limit) ? 9'h000 : 9'(div_count + 9'h001);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_tick       <= 1'b0;
            machine_count      <= 3'h0;
            machine_cycle_tick <= 1'b0;
        end else begin
            cpu_clk_tick       <= next_cpu_tick;
            machine_cycle_tick <= next_cpu_tick && (machine_count == MACHINE_LAST);
            if (next_cpu_tick) begin
                machine_count <= (machine_count == MACHINE_LAST) ? 3'h0 :
                                 3'(machine_count + 3'h1);
            end
        end
    end

    // Clock output, independent of Idle since only the enable bit and the oscillator gate it
    assign clkout_active = clock_out_enable && !is_xtal;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkout_count  <= 2'h0;
            clock_out_pin <= 1'b0;
            clock_out_oe  <= 1'b0;
        end else begin
            clock_out_oe <= clkout_active || (port_mode && port_pin_oe);
            if (clkout_active) begin
                if (next_cpu_tick) begin
                    if (clkout_count == CLKOUT_LAST) begin
                        clkout_count  <= 2'h0;
                        clock_out_pin <= !clock_out_pin;
                    end else begin
                        clkout_count <= 2'(clkout_count + 2'h1);
                    end
                end
            end else begin
                clkout_count  <= 2'h0;
                clock_out_pin <= port_mode ? port_pin_out : 1'b0;
            end
        end
    end

    // Wake-up stability count after Power Down
    assign wake_target = is_xtal ? WAKE_XTAL : WAKE_RC_EXT;

    always_comb begin
        next_wake_state = wake_state;
        case (wake_state)
            WAKE_RUN:   if (wake_request) next_wake_state = WAKE_COUNT;
            WAKE_COUNT: if (next_cpu_tick && (wake_count == 11'(wake_target - 11'h001)))
                            next_wake_state = WAKE_RUN;
            default:    next_wake_state = WAKE_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_state <= WAKE_RUN;
            wake_count <= 11'h000;
            cpu_hold   <= 1'b0;
        end else begin
            wake_state <= next_wake_state;
            cpu_hold   <= (next_wake_state == WAKE_COUNT);
            if (wake_state == WAKE_RUN) begin
                wake_count <= 11'h000;
            end else if (next_cpu_tick) begin
                wake_count <= 11'(wake_count + 11'h001);
            end
        end
    end

    a_xtal_no_clkout: assert property (@(posedge pclk) disable iff (!presetn)
        $past(is_xtal) |-> (!clock_out_oe && !clock_out_pin))
        else $error("clock output driven with crystal source");

    a_clkout_third: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(clkout_active) && clkout_active && $changed(clock_out_pin))
        |-> ($past(clkout_count) == CLKOUT_LAST && $past(next_cpu_tick)))
        else $error("clock output toggled off the third strobe");

    a_bo_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!brownout_disable && !brownout_irq_select && below)[*2] |-> brownout_reset)
        else $error("brownout reset not held while supply low");

    a_bo_irq_once: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_irq_request |=> !brownout_irq_request)
        else $error("brownout request longer than one event");

    a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_irq_request |-> $past(global_irq_enable && brownout_irq_enable))
        else $error("brownout request without both enables");

    a_bof_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (brownout_flag && !bof_clear) |=> brownout_flag)
        else $error("brownout flag lost without clear");

    a_bod_off: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(brownout_disable) && brownout_disable) |->
        (!brownout_reset && !brownout_irq_request && !bo_edge))
        else $error("brownout activity while disabled");

    a_pof_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (power_on_flag && !pof_clear) |=> power_on_flag)
        else $error("power-on flag lost without clear");

    a_div_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (div_active != cpu_clock_divider) |=> (div_count == 9'h000 && !cpu_clk_tick))
        else $error("divider did not reload on change");

endmodule

// *** tb/ccp_clock_follower.sv ***
// External device model that locks onto the clock output pin and times its period
`timescale 1ns/100ps

module ccp_clock_follower (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_line,
    input  wire logic clk_line_oe,
    output int        rise_count,
    output int        last_period
);
    int   since;
    logic prev;

    // Only a driven line counts; an undriven pin must not fake edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev        <= 1'h0;
            since       <= 0;
            rise_count  <= 0;
            last_period <= 0;
        end else begin
            prev  <= clk_line_oe & clk_line;
            since <= since + 1;
            if (clk_line_oe && clk_line && !prev) begin
                rise_count  <= rise_count + 1;
                last_period <= since + 1;
                since       <= 0;
            end
        end
    end
endmodule

// *** tb/test_cpu_clock_divider_and_power_monitor.sv ***
// Self-checking bench for the clock divider, clock output and power monitor
`timescale 1ns/100ps

module test_cpu_clock_divider_and_power_monitor;
    import ccp_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [2:0]  osc_select_cfg;
    logic        half_rate_config, brownout_level_select, supply_below_low;
    logic        supply_below_high, power_on_detect, wake_request, port_pin_out;
    logic        port_pin_oe, clock_out_pin, clock_out_oe, cpu_clk_tick;
    logic        machine_cycle_tick, cpu_hold, brownout_reset, brownout_irq_request;
    logic        err;
    int          failures, n_checks, cycles, irqs, rises, period, seed, g, e, n, r0;
    logic [11:0] ra[4] = '{ADDR_CLK_CTRL, ADDR_AUX, ADDR_IRQ_EN, ADDR_DIVIDER};
    logic [31:0] rm[4] = '{32'h10, 32'h60, 32'hA0, 32'hFF};

    ccp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .osc_select_cfg, .half_rate_config, .brownout_level_select,
        .supply_below_low, .supply_below_high, .power_on_detect, .wake_request,
        .port_pin_out, .port_pin_oe, .clock_out_pin, .clock_out_oe, .cpu_clk_tick,
        .machine_cycle_tick, .cpu_hold, .brownout_reset, .brownout_irq_request);

    ccp_clock_follower i_follow (.pclk, .presetn, .clk_line(clock_out_pin),
        .clk_line_oe(clock_out_oe), .rise_count(rises), .last_period(period));

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        if (brownout_irq_request === 1'h1) begin
            irqs <= irqs + 1;
        end
    end

    // Ceiling well above the longest divider and wake-up runs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            test_done;
        end
    end

    task automatic test_done;
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_num(input string nm, input int ex, input int got);
        n_checks++;
        if (got != ex) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Idle cycle after each transfer so psel never changes twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex,
                        input logic ex_err);
        apb(1'h0, a, 32'h0);
        chk32(nm, ex, rd);
        chk32("pslverr", {31'h0, ex_err}, {31'h0, err});
    endtask

    function automatic int exp_gap(input int dv, input logic h);
        return (h ? 2 : 1) * ((dv == 0) ? 1 : 2 * (dv + 1));
    endfunction

    task automatic gap(input logic m, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while ((m ? machine_cycle_tick : cpu_clk_tick) !== 1'h1 && k < 8000) begin
            @(posedge pclk);
            k++;
        end
        do begin
            @(posedge pclk);
            cnt++;
        end while ((m ? machine_cycle_tick : cpu_clk_tick) !== 1'h1 && cnt < 8000);
    endtask

    task automatic bo_case(input logic l, input logic use_lo, input logic [31:0] aux,
                           input logic [31:0] ien, input int e_irq,
                           input logic [31:0] e_flag, input logic e_rst);
        int i0;
        brownout_level_select <= l;
        apb(1'h1, ADDR_AUX, aux);
        apb(1'h1, ADDR_IRQ_EN, ien);
        apb(1'h1, ADDR_POWER, 32'h30);
        i0 = irqs;
        supply_below_low  <= use_lo;
        supply_below_high <= !use_lo;
        // Long hold proves the reset level persists while supply stays low
        cyc(40);
        chk32("brownout_reset", {31'h0, e_rst}, {31'h0, brownout_reset});
        chk_num("irq_pulses", e_irq, irqs - i0);
        rchk("power_flags", ADDR_POWER, e_flag, 1'h0);
        supply_below_low  <= 1'h0;
        supply_below_high <= 1'h0;
        cyc(10);
        chk32("reset_released", 32'h0, {31'h0, brownout_reset});
    endtask

    initial begin
        seed = 84786;
        pclk = 1'h0;
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {half_rate_config, supply_below_low, supply_below_high, power_on_detect} = '0;
        {wake_request, port_pin_out, port_pin_oe} = '0;
        brownout_level_select = 1'h1;
        osc_select_cfg = 3'h3;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (int a = 0; a < 20; a += 4) begin
            rchk("reset_value", a[11:0], 32'h0, 1'h0);
        end
        rchk("status", ADDR_STATUS, 32'h30, 1'h0);
        r = $random(seed);
        rchk("unmapped", 12'h800 | (r[11:0] & 12'h7FC), 32'h0, 1'h1);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                r = (p == 0) ? 32'hFFFFFFFF : $random(seed);
                apb(1'h1, ra[k], r);
                rchk("field_bits", ra[k], r & rm[k], 1'h0);
                apb(1'h1, ra[k], 32'h0);
            end
        end
        apb(1'h1, ADDR_STATUS, 32'hFFFFFFFF);
        rchk("status_ro", ADDR_STATUS, 32'h30, 1'h0);
        apb(1'h1, ADDR_CLK_CTRL, 32'h10);
        for (int k = 0; k < 6; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 255 : ($unsigned($random(seed)) % 30) + 2;
            half_rate_config <= k[0];
            apb(1'h1, ADDR_DIVIDER, n);
            e = exp_gap(n, k[0]);
            gap(1'h0, g);
            gap(1'h0, g);
            chk_num("cpu_tick_gap", e, g);
            gap(1'h1, g);
            gap(1'h1, g);
            chk_num("machine_gap", 6 * e, g);
            cyc(6 * e);
            chk_num("clock_out_period", 6 * e, period);
        end
        half_rate_config <= 1'h0;
        apb(1'h1, ADDR_DIVIDER, 32'h0);
        osc_select_cfg <= 3'h4;
        cyc(30);
        chk_num("ext_clock_out", 6, period);
        port_pin_out <= 1'h1;
        port_pin_oe  <= 1'h1;
        osc_select_cfg <= 3'h0;
        cyc(8);
        r0 = rises;
        cyc(30);
        chk_num("crystal_rises", r0, rises);
        chk32("crystal_pin", 32'h0, {30'h0, clock_out_oe, clock_out_pin});
        for (int k = 0; k < 2; k++) begin
            osc_select_cfg <= (k == 0) ? 3'h0 : 3'h3;
            cyc(8);
            wake_request <= 1'h1;
            @(posedge pclk);
            wake_request <= 1'h0;
            cyc(2);
            chk32("hold_start", 32'h1, {31'h0, cpu_hold});
            g = 0;
            while (cpu_hold === 1'h1 && g < 3000) begin
                @(posedge pclk);
                g++;
            end
            e = (k == 0) ? 1024 : 256;
            chk_num("wake_length_ok", 1, int'(g >= e - 3 && g <= e + 3));
        end
        // Software drops the clock output so the pin carries the port signals in the checks below
        apb(1'h1, ADDR_CLK_CTRL, 32'h0);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            port_pin_out <= r[0];
            port_pin_oe  <= r[1];
            cyc(3);
            chk32("port_pin", {30'h0, r[1:0]}, {30'h0, clock_out_oe, clock_out_pin});
        end
        bo_case(1'h1, 1'h1, 32'h00, 32'h00, 0, 32'h20, 1'h1);
        bo_case(1'h0, 1'h0, 32'h00, 32'h00, 0, 32'h20, 1'h1);
        bo_case(1'h0, 1'h1, 32'h00, 32'h00, 0, 32'h00, 1'h0);
        bo_case(1'h0, 1'h0, 32'h20, 32'hA0, 1, 32'h20, 1'h0);
        bo_case(1'h1, 1'h1, 32'h20, 32'h80, 0, 32'h20, 1'h0);
        bo_case(1'h0, 1'h0, 32'h20, 32'h20, 0, 32'h20, 1'h0);
        bo_case(1'h0, 1'h0, 32'h60, 32'hA0, 0, 32'h00, 1'h0);
        bo_case(1'h1, 1'h1, 32'h40, 32'h00, 0, 32'h00, 1'h0);
        apb(1'h1, ADDR_POWER, 32'h30);
        power_on_detect <= 1'h1;
        cyc(8);
        rchk("power_on_flag", ADDR_POWER, 32'h10, 1'h0);
        power_on_detect <= 1'h0;
        cyc(20);
        rchk("power_on_sticky", ADDR_POWER, 32'h10, 1'h0);
        apb(1'h1, ADDR_POWER, 32'h10);
        rchk("power_on_clear", ADDR_POWER, 32'h0, 1'h0);
        test_done;
    end
endmodule
